// ===== rtl/msc_counters.sv
// MAC statistics counter bank with APB register access
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module msc_counters
   import msc_pkg::*;
#(
   parameter logic [JAB_W-1:0] JAB_CYCLES_10M  = JAB_W'(JAB_10M_US * CLK_MHZ),
   parameter logic [JAB_W-1:0] JAB_CYCLES_100M = JAB_W'(JAB_100M_US * CLK_MHZ)
) (
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [7:0]     paddr,
   input  wire logic [31:0]    pwdata,
   output logic [31:0]         prdata,
   output logic                pready,
   output logic                pslverr,
   input  wire logic           carrier_sense_in,
   input  wire logic           rx_data_valid,
   input  wire logic           rx_nibble_tick,
   input  wire msc_rx_status_t rx_status,
   input  wire logic           collision_in,
   input  wire logic           transmit_enable_out,
   input  wire logic           tx_nibble_tick,
   input  wire logic           defer_active,
   input  wire logic           signal_quality_test,
   input  wire logic           receive_symbol_error,
   input  wire logic           speed_100
);

   msc_state_t       st_r;
   msc_state_t       st_nxt;
   logic [N16-1:0]   word_hit;
   logic [N16-1:0]   hi_hit;
   logic [N16-1:0]   lo_hit;
   logic [N16-1:0]   frz16;
   logic [N16-1:0]   clr16;
   logic [N16-1:0]   hold_set;
   logic [N16-1:0]   ev16;
   logic [N8-1:0]    frz8;
   logic [N8-1:0]    clr8;
   logic [N8-1:0]    ev8;
   logic [NPAIR-1:0] pair_hit;
   logic             ctrl_hit;
   logic             status_hit;
   logic             bad_access;
   logic             rd_req;
   logic             rd_done;
   logic             byte_mode;
   logic [1:0]       lanes_eff;
   logic             act;
   logic             act_fall;
   logic             col_rise;
   logic [JAB_W-1:0] jab_limit;
   logic [31:0]      rdata;

   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] base,
                                    input int unsigned idx, input int unsigned stride);
      return a == 8'(base + 8'(idx * stride));
   endfunction : addr_is

   assign byte_mode  = st_r.ctrl[CTRL_BYTE_MODE];
   // no lane selected means a full-word access
   assign lanes_eff  = (st_r.ctrl[CTRL_LANE_LSB +: 2] == 2'h0) ? 2'h3
                                                               : st_r.ctrl[CTRL_LANE_LSB +: 2];
   assign rd_req     = psel & ~pwrite;
   assign rd_done    = psel & penable & st_r.pready & ~pwrite;
   assign ctrl_hit   = paddr == ADDR_CTRL;
   assign status_hit = paddr == ADDR_STATUS;
   assign bad_access = ~(ctrl_hit | status_hit | (|word_hit) | (|hi_hit) | (|lo_hit)
                         | (|pair_hit)) | (pwrite & ~ctrl_hit);

   for (genvar g = 0; g < N16; g++) begin : g_dec16
      assign word_hit[g] = addr_is(paddr, ADDR_WORD16, g, WORD_STRIDE);
      assign hi_hit[g]   = addr_is(paddr, ADDR_BYTE16_HI, g, BYTE_STRIDE);
      assign lo_hit[g]   = addr_is(paddr, ADDR_BYTE16_LO, g, BYTE_STRIDE);
      // freeze covers the high-byte access itself so its carry cannot slip in
      assign frz16[g]    = st_r.hold16[g]
                           | (rd_req & ~byte_mode & word_hit[g])             // R9
                           | (rd_req & byte_mode & hi_hit[g]);               // R6
      assign clr16[g]    = rd_done & (byte_mode ? lo_hit[g] : word_hit[g]); // R7 R9
      assign hold_set[g] = rd_done & byte_mode & hi_hit[g];                 // R6
   end

   for (genvar p = 0; p < NPAIR; p++) begin : g_pair
      assign pair_hit[p] = addr_is(paddr, ADDR_PAIR, p, WORD_STRIDE);
   end

   for (genvar g = 0; g < N8; g++) begin : g_dec8
      assign frz8[g] = rd_req & pair_hit[g / 2] & lanes_eff[g % 2];  // R13 R15 R16
      assign clr8[g] = rd_done & pair_hit[g / 2] & lanes_eff[g % 2]; // R14 R15 R16
   end

   // media event detection
   assign act       = carrier_sense_in | rx_data_valid;
   assign act_fall  = st_r.act_d & ~act;
   assign col_rise  = collision_in & ~st_r.col_d;
   assign jab_limit = speed_100 ? JAB_CYCLES_100M : JAB_CYCLES_10M;

   assign ev16[IDX_RUNT]  = act_fall & (st_r.nib >= SHORT_NIB)
                            & (st_r.nib < MIN_FRAME_NIB);                            // R1
   assign ev16[IDX_SHORT] = act_fall & (st_r.nib < SHORT_NIB);                      // R2
   assign ev16[IDX_ALIGN] = rx_status.frame_done & rx_status.framing_error
                            & rx_status.crc_error;                                  // R3
   assign ev16[IDX_TXCOL] = col_rise & transmit_enable_out;                         // R21
   assign ev16[IDX_RXCOL] = col_rise & ~transmit_enable_out & ~signal_quality_test; // R10
   assign ev8[IDX_JAB]      = transmit_enable_out & ~st_r.jab_done
                              & (st_r.jab_cnt >= jab_limit);                        // R11
   assign ev8[IDX_OVERSIZE] = rx_status.frame_done
                              & (rx_status.byte_count > MAX_FRAME_LEN);             // R17
   assign ev8[IDX_DEFER]    = defer_active & ~st_r.defer_done
                              & (st_r.defer_cnt > DEFER_NIB);                       // R18
   assign ev8[IDX_LATE]     = col_rise & transmit_enable_out
                              & (st_r.tx_nib > LATE_NIB);                           // R19
   assign ev8[IDX_SYMERR]   = receive_symbol_error & ~st_r.receive_symbol_error_d & speed_100;     // R20

   always_comb begin
      rdata = 32'h0000_0000;
      if (ctrl_hit) begin
         rdata[2:0] = st_r.ctrl;
      end
      if (status_hit) begin
         rdata = {19'h0_0000, st_r.pend16, 3'h0, st_r.hold16};
      end
      for (int i = 0; i < N16; i++) begin
         if (word_hit[i]) begin
            rdata = {16'h0000, st_r.c16[i]};
         end
         if (hi_hit[i]) begin
            rdata = {24'h00_0000, st_r.c16[i][15:8]};
         end
         if (lo_hit[i]) begin
            rdata = {24'h00_0000, st_r.c16[i][7:0]};
         end
      end
      // third pair's upper lane has no counter in this bank and reads as zero
      for (int i = 0; i < N8; i++) begin
         if (pair_hit[i / 2] && lanes_eff[i % 2]) begin
            rdata[8 * (i % 2) +: 8] = st_r.c8[i];
         end
      end
   end

   always_comb begin
      st_nxt            = st_r;
      st_nxt.act_d      = act;
      st_nxt.col_d      = collision_in;
      st_nxt.receive_symbol_error_d    = receive_symbol_error;
      // activity length in nibbles, held at the falling edge for classification
      if (!act) begin
         st_nxt.nib = 8'h00;
      end else if (rx_nibble_tick && st_r.nib != MAX8) begin
         st_nxt.nib = st_r.nib + 8'h01;
      end
      if (!transmit_enable_out) begin
         st_nxt.tx_nib   = 8'h00;
         st_nxt.jab_cnt  = '0;
         st_nxt.jab_done = 1'b0;
      end else begin
         if (tx_nibble_tick && st_r.tx_nib != MAX8) begin
            st_nxt.tx_nib = st_r.tx_nib + 8'h01;
         end
         if (ev8[IDX_JAB]) begin
            st_nxt.jab_done = 1'b1;
         end else if (!st_r.jab_done) begin
            st_nxt.jab_cnt = st_r.jab_cnt + 1'b1;
         end
      end
      if (!defer_active) begin
         st_nxt.defer_cnt  = 13'h0000;
         st_nxt.defer_done = 1'b0;
      end else if (ev8[IDX_DEFER]) begin
         st_nxt.defer_done = 1'b1;
      end else if (tx_nibble_tick && !st_r.defer_done) begin
         st_nxt.defer_cnt = st_r.defer_cnt + 13'h0001;
      end
      for (int i = 0; i < N16; i++) begin
         if (clr16[i]) begin
            // an event at the completing edge is also kept
            st_nxt.c16[i]    = (st_r.pend16[i] | ev16[i]) ? PRESET16 : 16'h0000; // R7 R8 R9
            st_nxt.pend16[i] = 1'b0;
            st_nxt.hold16[i] = 1'b0;
         end else begin
            if (hold_set[i]) begin
               st_nxt.hold16[i] = 1'b1; // R6
            end
            if (ev16[i]) begin
               if (frz16[i]) begin
                  st_nxt.pend16[i] = 1'b1; // R8
               end else if (st_r.c16[i] != MAX16) begin
                  st_nxt.c16[i] = st_r.c16[i] + 16'h0001; // R4
               end
            end
         end
      end
      for (int i = 0; i < N8; i++) begin
         if (clr8[i]) begin
            st_nxt.c8[i]    = (st_r.pend8[i] | ev8[i]) ? PRESET8 : 8'h00; // R13 R14
            st_nxt.pend8[i] = 1'b0;
         end else if (ev8[i]) begin
            if (frz8[i]) begin
               st_nxt.pend8[i] = 1'b1; // R13
            end else if (st_r.c8[i] != MAX8) begin
               st_nxt.c8[i] = st_r.c8[i] + 8'h01; // R12
            end
         end
      end
      // one wait state: data registered in the first access cycle, completes in the next
      if (psel && penable && !st_r.pready) begin
         st_nxt.pready  = 1'b1;
         st_nxt.prdata  = rdata;
         st_nxt.pslverr = bad_access;
      end else if (psel && penable) begin
         st_nxt.pready  = 1'b0;
         st_nxt.pslverr = 1'b0;
         if (pwrite && ctrl_hit) begin
            st_nxt.ctrl = pwdata[2:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata  = st_r.prdata;
   assign pready  = st_r.pready;
   assign pslverr = st_r.pslverr;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_RUNT_CNT: assert property (act_fall && st_r.nib >= SHORT_NIB // R1
      && st_r.nib < MIN_FRAME_NIB && !frz16[0] && !clr16[0] && st_r.c16[0] != MAX16
      |=> st_r.c16[0] == $past(st_r.c16[0]) + 16'h0001)
      else $error("runt event not counted");
   AST_SHORT_CNT: assert property (act_fall && st_r.nib < SHORT_NIB && !frz16[1] // R2
      && !clr16[1] && st_r.c16[1] != MAX16 |=> st_r.c16[1] == $past(st_r.c16[1]) + 16'h0001)
      else $error("short event not counted");
   AST_ALIGN_ONLY: assert property (!clr16[2] && !(rx_status.frame_done // R3
      && rx_status.framing_error && rx_status.crc_error) |=> $stable(st_r.c16[2]))
      else $error("alignment counter moved without cause");
   AST_SAT16: assert property (st_r.c16[3] == MAX16 && !clr16[3] |=> st_r.c16[3] == MAX16) // R4
      else $error("16-bit counter left saturation");
   AST_FREEZE: assert property (st_r.hold16[4] && !clr16[4] |=> $stable(st_r.c16[4])) // R6
      else $error("frozen counter changed");
   AST_LO_CLEAR: assert property (clr16[4] && byte_mode // R7 R8
      |=> st_r.c16[4] == ($past(st_r.pend16[4] | ev16[4]) ? PRESET16 : 16'h0000))
      else $error("low byte read gave wrong value");
   AST_WORD_RD: assert property (rd_req && !byte_mode && word_hit[4] && !penable // R9
      ##1 rd_req && penable && !st_r.pready ##1 rd_done |=> st_r.c16[4] <= PRESET16)
      else $error("word read did not clear counter");
   AST_RXCOL_EXCL: assert property (col_rise && (transmit_enable_out || signal_quality_test) // R10
      && !clr16[4] |=> $stable(st_r.c16[4]))
      else $error("receive collision counted wrongly");
   AST_SAT8: assert property (st_r.c8[4] == MAX8 && !clr8[4] |=> st_r.c8[4] == MAX8) // R12
      else $error("8-bit counter left saturation");
   AST_RD8: assert property (clr8[2] // R13 R14
      |=> st_r.c8[2] == ($past(st_r.pend8[2] | ev8[2]) ? PRESET8 : 8'h00))
      else $error("8-bit read gave wrong value");
   AST_PAIR_BOTH: assert property (rd_done && pair_hit[0] && lanes_eff == 2'h3 // R15
      |=> st_r.c8[0] <= PRESET8 && st_r.c8[1] <= PRESET8)
      else $error("pair read did not clear both");
   AST_LANE_ONE: assert property (rd_done && pair_hit[1] && lanes_eff == 2'h1 && !ev8[3] // R16
      |=> $stable(st_r.c8[3]))
      else $error("unselected lane counter changed");
   AST_LATE_EARLY: assert property (col_rise && st_r.tx_nib <= LATE_NIB && !clr8[3] // R19
      |=> $stable(st_r.c8[3]))
      else $error("early collision counted as late");
   AST_SYM_10M: assert property (!speed_100 && !clr8[4] |=> $stable(st_r.c8[4])) // R20
      else $error("symbol error counted at 10 Mbit/s");
   AST_TXCOL_CNT: assert property (col_rise && transmit_enable_out && !frz16[3] // R21
      && !clr16[3] && st_r.c16[3] != MAX16 |=> st_r.c16[3] == $past(st_r.c16[3]) + 16'h0001)
      else $error("transmit collision not counted");

   COV_BYTE_SEQ: cover property (hold_set[4] ##[1:20] clr16[4]);
   COV_PEND_PRESET: cover property (st_r.pend16[1] && clr16[1]);
   COV_PAIR_LANE: cover property (rd_done && pair_hit[1] && lanes_eff == 2'h2);
   COV_JABBER: cover property (ev8[IDX_JAB]);

endmodule : msc_counters

// ===== rtl/msc_pkg.sv
// Package: constants, register map and carrier types of the MAC statistics counter bank
// Functional notes
// R1 - runt counter counts activity longer than short limit but shorter than 64 bytes; the code also counts activity of exactly the short limit
// R2 - short-event counter counts receive activity shorter than the short-event limit
// R3 - alignment counter counts frames having both framing error and CRC error
// R4 - 16-bit counters are read-only and stop at FFFF
// R5 - host reads high byte before low byte in byte mode
// R6 - high-byte read freezes the counter until the low byte is read
// R7 - low-byte read clears the counter when no event arrived while frozen
// R8 - event during freeze makes the low-byte read load one instead of zero
// R9 - word read freezes counter during access, then clears or presets to one
// R10 - receive collisions exclude transmit collisions and signal-quality-test collisions
// R11 - jabber counter counts transmissions outlasting the jabber lockup window
// R12 - 8-bit counters stop at FF
// R13 - 8-bit counter frozen while read; event during read loads one afterwards
// R14 - 8-bit counter cleared after a read with no event during it
// R15 - word read of a pair reads and clears both 8-bit counters
// R16 - single byte lane reads and clears only that counter of the pair
// R17 - oversize counter counts received frames longer than 1518 bytes
// R18 - excess-defer counter counts defers longer than 3036 byte times
// R19 - late-collision counter counts collisions over 512 bit times after transmit start
// R20 - symbol-error counter counts receive symbol errors at 100 Mbit/s only
// R21 - transmit-collision counter counts collisions during own transmission
package msc_pkg;
   localparam int unsigned CLK_MHZ          = 40;
   localparam int unsigned N16              = 5;
   localparam int unsigned N8               = 5;
   localparam int unsigned NPAIR            = 3;
   // register map, byte addresses
   localparam logic [7:0]  ADDR_CTRL        = 8'h00;
   localparam logic [7:0]  ADDR_STATUS      = 8'h04;
   localparam logic [7:0]  ADDR_WORD16      = 8'h10;
   localparam logic [7:0]  ADDR_BYTE16_HI   = 8'h40;
   localparam logic [7:0]  ADDR_BYTE16_LO   = 8'h44;
   localparam logic [7:0]  ADDR_PAIR        = 8'h80;
   localparam int unsigned WORD_STRIDE      = 4;
   localparam int unsigned BYTE_STRIDE      = 8;
   localparam int unsigned CTRL_BYTE_MODE   = 0;
   localparam int unsigned CTRL_LANE_LSB    = 1;
   localparam logic [2:0]  CTRL_RESET       = 3'h0;
   localparam logic [15:0] MAX16            = 16'hFFFF;
   localparam logic [7:0]  MAX8             = 8'hFF;
   localparam logic [15:0] PRESET16         = 16'h0001;
   localparam logic [7:0]  PRESET8          = 8'h01;
   // counter indices
   localparam int unsigned IDX_RUNT         = 0;
   localparam int unsigned IDX_SHORT        = 1;
   localparam int unsigned IDX_ALIGN        = 2;
   localparam int unsigned IDX_TXCOL        = 3;
   localparam int unsigned IDX_RXCOL        = 4;
   localparam int unsigned IDX_JAB          = 0;
   localparam int unsigned IDX_OVERSIZE     = 1;
   localparam int unsigned IDX_DEFER        = 2;
   localparam int unsigned IDX_LATE         = 3;
   localparam int unsigned IDX_SYMERR       = 4;
   // media timing, converted to nibble ticks; the frame length limit stays in bytes
   localparam int unsigned SHORT_EVENT_BITS = 76;
   localparam int unsigned MIN_FRAME_BYTES  = 64;
   localparam int unsigned MAX_FRAME_BYTES  = 1518;
   localparam int unsigned LATE_COL_BITS    = 512;
   localparam int unsigned MAX_DEFER_BYTES  = 3036;
   localparam int unsigned BITS_PER_NIB     = 4;
   localparam logic [7:0]  SHORT_NIB        = 8'(SHORT_EVENT_BITS / BITS_PER_NIB);
   localparam logic [7:0]  MIN_FRAME_NIB    = 8'(MIN_FRAME_BYTES * 8 / BITS_PER_NIB);
   localparam logic [7:0]  LATE_NIB         = 8'(LATE_COL_BITS / BITS_PER_NIB);
   localparam logic [11:0] MAX_FRAME_LEN    = 12'(MAX_FRAME_BYTES);
   localparam logic [12:0] DEFER_NIB        = 13'(MAX_DEFER_BYTES * 8 / BITS_PER_NIB);
   // jabber window, microseconds
   localparam int unsigned JAB_10M_US       = 5000;
   localparam int unsigned JAB_100M_US      = 500;
   localparam int unsigned JAB_W            = 18;

   typedef struct packed {
      logic        frame_done;
      logic        framing_error;
      logic        crc_error;
      logic [11:0] byte_count;
   } msc_rx_status_t;

   typedef struct packed {
      logic [N16-1:0][15:0] c16;
      logic [N8-1:0][7:0]   c8;
      logic [N16-1:0]       hold16;
      logic [N16-1:0]       pend16;
      logic [N8-1:0]        pend8;
      logic [7:0]           nib;
      logic [7:0]           tx_nib;
      logic [JAB_W-1:0]     jab_cnt;
      logic                 jab_done;
      logic [12:0]          defer_cnt;
      logic                 defer_done;
      logic                 act_d;
      logic                 col_d;
      logic                 receive_symbol_error_d;
      logic [2:0]           ctrl;
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
   } msc_state_t;
endpackage : msc_pkg

// ===== tb/mac_statistics_counters_test.sv
// self-checking bench for the statistics counter bank
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module mac_statistics_counters_test
   import msc_pkg::*;
;
   logic           pclk, presetn, psel, penable, pwrite;
   logic [7:0]     paddr;
   logic [31:0]    pwdata, prdata, q;
   logic           pready, pslverr, e;
   logic           carrier_sense_in, rx_data_valid, rx_nibble_tick, collision_in;
   msc_rx_status_t rx_status;
   logic           transmit_enable_out, tx_nibble_tick, defer_active, tick_en;
   logic           signal_quality_test, receive_symbol_error, speed_100;
   int             err_total, comparisons;

   msc_counters #(.JAB_CYCLES_10M(JAB_W'(40)), .JAB_CYCLES_100M(JAB_W'(20))) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .carrier_sense_in(carrier_sense_in), .rx_data_valid(rx_data_valid),
      .rx_nibble_tick(rx_nibble_tick), .rx_status(rx_status), .collision_in(collision_in),
      .transmit_enable_out(transmit_enable_out), .tx_nibble_tick(tx_nibble_tick),
      .defer_active(defer_active), .signal_quality_test(signal_quality_test),
      .receive_symbol_error(receive_symbol_error), .speed_100(speed_100));

   msc_phy_model phy_u (
      .pclk(pclk), .carrier_sense_in(carrier_sense_in), .rx_data_valid(rx_data_valid),
      .rx_nibble_tick(rx_nibble_tick), .rx_status(rx_status), .collision_in(collision_in),
      .receive_symbol_error(receive_symbol_error));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // transmit nibble time every second cycle while enabled
   always @(posedge pclk) tx_nibble_tick <= tick_en & ~tx_nibble_tick;

   task automatic end_of_test();
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // one idle edge so a following call never re-drives psel in this time step
      @(posedge pclk);
      if (n >= 16) begin
         err_total++;
         end_of_test();
      end
   endtask : apb

   task automatic rchk(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK({e, q}, {1'b0, x})
   endtask : rchk

   function automatic logic [7:0] w16(input int unsigned i);
      return ADDR_WORD16 + 8'(i * WORD_STRIDE);
   endfunction : w16

   task automatic t_reset();
      rchk(ADDR_STATUS, 32'h0);
      apb(1'b1, w16(IDX_RUNT), 32'h0000_00AA);
      `CHK(e, 1'b1)
      apb(1'b0, 8'hFC, 32'h0);
      `CHK(e, 1'b1)
   endtask : t_reset

   task automatic t_rx();
      phy_u.activity(18, 1'b0);
      phy_u.activity(19, 1'b1);
      phy_u.activity(128, 1'b0);
      phy_u.frame(1'b1, 1'b1, 12'd100);
      phy_u.frame(1'b0, 1'b1, 12'd100);
      phy_u.frame(1'b1, 1'b0, 12'd100);
      phy_u.frame(1'b0, 1'b0, 12'd1519);
      phy_u.frame(1'b0, 1'b0, 12'd1518);
      rchk(w16(IDX_RUNT), 32'h1);
      rchk(w16(IDX_SHORT), 32'h1);
      rchk(w16(IDX_ALIGN), 32'h1);
      rchk(w16(IDX_RUNT), 32'h0);
   endtask : t_rx

   task automatic t_tx();
      speed_100           <= 1'b1;
      transmit_enable_out <= 1'b1;
      tick_en             <= 1'b1;
      repeat (10) @(posedge pclk);
      phy_u.collide();
      repeat (300) @(posedge pclk);
      phy_u.collide();
      transmit_enable_out <= 1'b0;
      signal_quality_test <= 1'b1;
      phy_u.collide();
      signal_quality_test <= 1'b0;
      phy_u.collide();
      defer_active <= 1'b1;
      repeat (12200) @(posedge pclk);
      defer_active <= 1'b0;
      tick_en      <= 1'b0;
      rchk(w16(IDX_TXCOL), 32'h2);
      rchk(w16(IDX_RXCOL), 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h2);
      rchk(ADDR_PAIR + 8'h04, 32'h01);
      apb(1'b1, ADDR_CTRL, 32'h4);
      rchk(ADDR_PAIR + 8'h04, 32'h0100);
      apb(1'b1, ADDR_CTRL, 32'h0);
   endtask : t_tx

   task automatic t_pair();
      rchk(ADDR_PAIR, 32'h0101);
      rchk(ADDR_PAIR, 32'h0);
   endtask : t_pair

   task automatic t_sym();
      speed_100 <= 1'b0;
      phy_u.symerr();
      speed_100 <= 1'b1;
      repeat (3) phy_u.symerr();
      rchk(ADDR_PAIR + 8'h08, 32'h3);
      repeat (260) phy_u.symerr();
      rchk(ADDR_PAIR + 8'h08, 32'hFF);
      fork
         begin
            @(posedge pclk);
            phy_u.symerr();
         end
         apb(1'b0, ADDR_PAIR + 8'h08, 32'h0);
      join
      `CHK(q, 32'h0)
      rchk(ADDR_PAIR + 8'h08, 32'h1);
   endtask : t_sym

   task automatic t_byte();
      logic [7:0] hi, lo;
      hi = ADDR_BYTE16_HI + 8'(IDX_RXCOL * BYTE_STRIDE);
      lo = ADDR_BYTE16_LO + 8'(IDX_RXCOL * BYTE_STRIDE);
      apb(1'b1, ADDR_CTRL, 32'h1);
      phy_u.collide();
      rchk(hi, 32'h0);
      // second event lands while the count is frozen
      phy_u.collide();
      apb(1'b0, lo, 32'h0);
      `CHK(q[7:0], 8'h01)
      rchk(hi, 32'h0);
      apb(1'b0, lo, 32'h0);
      `CHK(q[7:0], 8'h01)
      rchk(hi, 32'h0);
      apb(1'b0, lo, 32'h0);
      `CHK(q[7:0], 8'h00)
      apb(1'b1, ADDR_CTRL, 32'h0);
   endtask : t_byte

   task automatic t_mid();
      fork
         begin
            @(posedge pclk);
            phy_u.collide();
         end
         apb(1'b0, w16(IDX_RXCOL), 32'h0);
      join
      `CHK(q, 32'h0)
      rchk(w16(IDX_RXCOL), 32'h1);
   endtask : t_mid

   initial begin
      err_total = 0;
      comparisons = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {transmit_enable_out, tick_en, defer_active, signal_quality_test, speed_100} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_rx();
      t_tx();
      t_pair();
      t_sym();
      t_byte();
      t_mid();
      end_of_test();
   end

   // hang guard
   initial begin
      repeat (100000) @(posedge pclk);
      err_total++;
      end_of_test();
   end
endmodule : mac_statistics_counters_test

// ===== tb/msc_phy_model.sv
// phy-side model: receive activity, frame status, collisions and symbol errors
`timescale 1ns/1ps
module msc_phy_model
   import msc_pkg::*;
(
   input  wire logic      pclk,
   output logic           carrier_sense_in,
   output logic           rx_data_valid,
   output logic           rx_nibble_tick,
   output msc_rx_status_t rx_status,
   output logic           collision_in,
   output logic           receive_symbol_error
);
   initial begin
      carrier_sense_in     = 1'b0;
      rx_data_valid        = 1'b0;
      rx_nibble_tick       = 1'b0;
      rx_status            = '0;
      collision_in         = 1'b0;
      receive_symbol_error = 1'b0;
   end

   // n nibbles of activity on either receive qualifier
   task automatic activity(input int n, input logic use_dv);
      if (use_dv) rx_data_valid <= 1'b1;
      else carrier_sense_in <= 1'b1;
      repeat (n) begin
         rx_nibble_tick <= 1'b1;
         @(posedge pclk);
         rx_nibble_tick <= 1'b0;
         @(posedge pclk);
      end
      rx_data_valid    <= 1'b0;
      carrier_sense_in <= 1'b0;
      @(posedge pclk);
   endtask : activity

   task automatic frame(input logic fe, input logic crc, input logic [11:0] len);
      rx_status <= '{1'b1, fe, crc, len};
      @(posedge pclk);
      // status is only meaningful at the done pulse, so it is scrambled after
      rx_status <= '{1'b0, ~fe, ~crc, ~len};
      @(posedge pclk);
   endtask : frame

   task automatic collide();
      collision_in <= 1'b1;
      repeat (2) @(posedge pclk);
      collision_in <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : collide

   task automatic symerr();
      receive_symbol_error <= 1'b1;
      @(posedge pclk);
      receive_symbol_error <= 1'b0;
      @(posedge pclk);
   endtask : symerr
endmodule : msc_phy_model
